// ---- hw/tds_burst_adc.sv ----
/*
 tds_burst_adc: one charge-transfer burst read as a single-slope conversion.
 assumes level_reached comes from the sample-cap comparator, synchronous.
*/
`timescale 1ns/1ps
`default_nettype none
module tds_burst_adc #(
   parameter int BITS = tds_pkg::ADC_BITS
) (
   input wire logic core_clk, // core clock
   input wire logic rst, // sync reset, high
   input wire logic start, // begin a burst
   input wire logic level_reached, // sample level reached
   output logic charge_sw, // charge switch strobe
   output logic xfer_sw, // transfer switch strobe
   output logic done, // one-cycle result valid
   output logic [BITS-1:0] result // transfer count
);
   tds_pkg::tds_adc_state_type st_r, st_nxt;
   logic [BITS-1:0] cnt_r, cnt_nxt;
   wire cnt_full = (cnt_r == {BITS{1'b1}});
   // ===========================================
   // burst sequencing: each charge/transfer pair is one converter count
   always_comb begin
      st_nxt = st_r;
      cnt_nxt = cnt_r;
      unique case (st_r)
         tds_pkg::ADC_IDLE: begin
            if (start) begin
               st_nxt = tds_pkg::ADC_CHG;
               cnt_nxt = '0;
            end
         end
         tds_pkg::ADC_CHG: st_nxt = tds_pkg::ADC_XFR;
         tds_pkg::ADC_XFR: begin
            cnt_nxt = cnt_r + 1'b1;
            // end the burst at full count so a broken comparator cannot hang it; the count wraps to zero there
            if (level_reached || cnt_full) begin
               st_nxt = tds_pkg::ADC_DONE;
            end else begin
               st_nxt = tds_pkg::ADC_CHG;
            end
         end
         tds_pkg::ADC_DONE: st_nxt = tds_pkg::ADC_IDLE;
         default: st_nxt = tds_pkg::ADC_IDLE;
      endcase
   end
   // ===========================================
   // state and strobes, strobes aligned to state
   always_ff @(posedge core_clk) begin
      if (rst) begin
         st_r <= tds_pkg::ADC_IDLE;
         cnt_r <= '0;
         charge_sw <= 1'b0;
         xfer_sw <= 1'b0;
         done <= 1'b0;
         result <= '0;
      end else begin
         st_r <= st_nxt;
         cnt_r <= cnt_nxt;
         charge_sw <= (st_nxt == tds_pkg::ADC_CHG);
         xfer_sw <= (st_nxt == tds_pkg::ADC_XFR);
         done <= (st_nxt == tds_pkg::ADC_DONE);
         if (st_nxt == tds_pkg::ADC_DONE) begin
            result <= cnt_nxt;
         end
      end
   end
endmodule
`default_nettype wire

// ---- hw/tds_pkg.sv ----
/*
 tds_pkg: constants, states and strap carrier for the touch detect sequencer.
 assumes a single 10 MHz core clock; all counts derive from it.
*/
package tds_pkg;
   // ===========================================
   // timing
   localparam int CLK_HZ = 10_000_000;
   localparam int TONE_HZ = 4000;
   localparam int TONE_MS = 75;
   localparam int TONE_HALF_CYC = CLK_HZ / (2 * TONE_HZ);
   localparam int TONE_CYC = (CLK_HZ / 1000) * TONE_MS;
   localparam int RECAL_SHORT_S = 10;
   localparam int RECAL_LONG_S = 60;
   localparam int RECAL_SHORT_CYC = CLK_HZ * RECAL_SHORT_S;
   localparam int RECAL_LONG_CYC = CLK_HZ * RECAL_LONG_S;
   localparam int BURST_PERIOD_US = 1000;
   localparam int BURST_CYC = (CLK_HZ / 1_000_000) * BURST_PERIOD_US;
   localparam int PULSE_US = 50;
   localparam int PULSE_CYC = (CLK_HZ / 1_000_000) * PULSE_US;
   localparam int HB_US = 20;
   localparam int HB_CYC = (CLK_HZ / 1_000_000) * HB_US;
   localparam int HB_BURSTS = 16;
   // ===========================================
   // conversion and detection
   localparam int ADC_BITS = 14;
   localparam int FILT_CONFIRM = 4;
   localparam logic [2:0] GAIN_SHIFT_HIGH = 3'h5;
   localparam logic [2:0] GAIN_SHIFT_MID = 3'h4;
   localparam logic [2:0] GAIN_SHIFT_LOW = 3'h3;
   localparam logic [1:0] GAIN_OPEN = 2'h0;
   localparam logic [1:0] GAIN_MID = 2'h1;
   localparam logic [1:0] GAIN_LOW = 2'h2;
   // ===========================================
   // register map (byte offsets)
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STAT = 8'h04;
   localparam logic [7:0] REG_RESULT = 8'h08;
   localparam logic [7:0] REG_REF = 8'h0c;
   localparam logic [7:0] REG_INT_STAT = 8'h10;
   localparam logic [7:0] REG_INT_MASK = 8'h14;
   localparam int CTRL_EN_BIT = 0;
   localparam int CTRL_RECAL_BIT = 1;
   localparam logic [1:0] CTRL_RST = 2'h1;
   localparam int INT_W = 4;
   localparam int INT_ON_BIT = 0;
   localparam int INT_OFF_BIT = 1;
   localparam int INT_RECAL_BIT = 2;
   localparam int INT_CONV_BIT = 3;
   localparam logic [3:0] INT_MASK_RST = 4'h0;
   // ===========================================
   // types
   typedef struct packed {
      logic [1:0] gain;
      logic recal_long;
      logic toggle;
      logic pulse;
   } tds_strap_type;
   typedef enum logic [3:0] {
      ADC_IDLE = 4'b0001,
      ADC_CHG = 4'b0010,
      ADC_XFR = 4'b0100,
      ADC_DONE = 4'b1000
   } tds_adc_state_type;
   typedef enum logic [2:0] {
      SEQ_WAIT = 3'b001,
      SEQ_BURST = 3'b010,
      SEQ_EVAL = 3'b100
   } tds_seq_state_type;
endpackage

// ---- hw/tds_touch_core.sv ----
/*
 tds_touch_core: detection core with wishbone registers and interrupt.
 assumes straps are static after reset and analog switches sit outside.
*/
`timescale 1ns/1ps
`default_nettype none
module tds_touch_core #(
   parameter bit ACTIVE_LOW = 1'b1,
   parameter int BURST_CYC = tds_pkg::BURST_CYC,
   parameter int TONE_CYC = tds_pkg::TONE_CYC,
   parameter int RECAL_SHORT_CYC = tds_pkg::RECAL_SHORT_CYC,
   parameter int RECAL_LONG_CYC = tds_pkg::RECAL_LONG_CYC
) (
   input wire logic core_clk, // 10 MHz clock
   input wire logic rst, // sync reset, high
   input wire logic wb_cyc_i, // bus cycle
   input wire logic wb_stb_i, // strobe
   input wire logic wb_we_i, // write enable
   input wire logic [7:0] wb_adr_i, // byte address
   input wire logic [3:0] wb_sel_i, // byte lanes
   input wire logic [31:0] wb_dat_i, // write data
   output logic [31:0] wb_dat_o, // read data
   output logic wb_ack_o, // ack
   output logic irq, // level interrupt
   input wire tds_pkg::tds_strap_type straps, // option pins
   input wire logic level_reached, // sample-cap comparator
   output logic charge_sw, // charge switch strobe
   output logic xfer_sw, // transfer switch strobe
   output logic det_out, // detect output pin
   output logic sense_terminal_a_drv, // tone drive, terminal a
   output logic sense_terminal_b_drv // tone drive, terminal b
);
   localparam int AB = tds_pkg::ADC_BITS;
   localparam int BT_W = $clog2(BURST_CYC + 1);
   localparam int TN_W = $clog2(TONE_CYC + 1);
   localparam int RC_W = $clog2(RECAL_LONG_CYC + 1);
   localparam int TH_W = $clog2(tds_pkg::TONE_HALF_CYC + 1);
   localparam int PU_W = $clog2(tds_pkg::PULSE_CYC + 1);
   localparam int HB_W = $clog2(tds_pkg::HB_CYC + 1);
   localparam int HN_W = $clog2(tds_pkg::HB_BURSTS + 1);

   tds_pkg::tds_seq_state_type seq_r, seq_nxt;
   logic [BT_W-1:0] bt_r;
   logic [AB-1:0] res_r, ref_r;
   logic ref_ok_r;
   logic [2:0] filt_r;
   logic detect_r, tog_r;
   logic [RC_W-1:0] rc_r;
   logic [TN_W-1:0] tone_r;
   logic [TH_W-1:0] half_r;
   logic phase_r;
   logic [PU_W-1:0] pulse_r;
   logic [HB_W-1:0] hb_r;
   logic [HN_W-1:0] hbn_r;
   logic [1:0] ctrl_r;
   logic recal_req_r;
   logic [tds_pkg::INT_W-1:0] int_stat_r, int_mask_r;
   logic adc_done;
   logic [AB-1:0] adc_res;
   logic burst_go;

   // ===========================================
   // burst converter
   tds_burst_adc #(.BITS(AB)) u_adc (
      .core_clk(core_clk),
      .rst(rst),
      .start(burst_go),
      .level_reached(level_reached),
      .charge_sw(charge_sw),
      .xfer_sw(xfer_sw),
      .done(adc_done),
      .result(adc_res)
   );

   // ===========================================
   // burst scheduling: long idle gap, then one short burst
   wire bt_wrap = (bt_r == BT_W'(BURST_CYC - 1));
   wire enabled = ctrl_r[tds_pkg::CTRL_EN_BIT];
   assign burst_go = bt_wrap && enabled && (seq_r == tds_pkg::SEQ_WAIT);
   wire eval = (seq_r == tds_pkg::SEQ_EVAL);

   always_comb begin
      seq_nxt = seq_r;
      unique case (seq_r)
         tds_pkg::SEQ_WAIT: if (burst_go) seq_nxt = tds_pkg::SEQ_BURST;
         tds_pkg::SEQ_BURST: if (adc_done) seq_nxt = tds_pkg::SEQ_EVAL;
         tds_pkg::SEQ_EVAL: seq_nxt = tds_pkg::SEQ_WAIT;
         default: seq_nxt = tds_pkg::SEQ_WAIT;
      endcase
   end

   // idle timer runs free so burst spacing does not depend on burst length while each burst ends within one BURST_CYC period
   always_ff @(posedge core_clk) begin
      if (rst) begin
         seq_r <= tds_pkg::SEQ_WAIT;
         bt_r <= '0;
      end else begin
         seq_r <= seq_nxt;
         bt_r <= bt_wrap ? '0 : bt_r + 1'b1;
      end
   end

   // ===========================================
   // threshold: fewer transfers than reference means added load
   wire [2:0] gain_shift =
      (straps.gain == tds_pkg::GAIN_MID) ? tds_pkg::GAIN_SHIFT_MID :
      (straps.gain == tds_pkg::GAIN_LOW) ? tds_pkg::GAIN_SHIFT_LOW :
      tds_pkg::GAIN_SHIFT_HIGH;
   wire [AB-1:0] thr = ref_r >> gain_shift;
   wire below = (res_r < ref_r);
   wire [AB-1:0] delta = ref_r - res_r;
   wire hit = ref_ok_r && below && (delta > thr);

   // ===========================================
   // consensus filter and recalibration timeout
   wire confirm = eval && hit && (filt_r == 3'(tds_pkg::FILT_CONFIRM - 1));
   wire [RC_W-1:0] rc_lim = straps.recal_long ? RC_W'(RECAL_LONG_CYC - 1) :
      RC_W'(RECAL_SHORT_CYC - 1);
   wire timeout = detect_r && (rc_r == rc_lim);
   wire recal = timeout || recal_req_r;
   wire det_rise = confirm && !detect_r;
   wire det_fall = detect_r && (recal || (eval && !hit));

   always_ff @(posedge core_clk) begin
      if (rst || recal) begin
         filt_r <= '0;
      end else if (eval) begin
         // any miss restarts the count, saturate at four
         if (!hit) begin
            filt_r <= '0;
         end else if (filt_r != 3'(tds_pkg::FILT_CONFIRM)) begin
            filt_r <= filt_r + 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         detect_r <= 1'b0;
         rc_r <= '0;
      end else begin
         detect_r <= (detect_r || det_rise) && !det_fall;
         rc_r <= (detect_r && !timeout) ? rc_r + 1'b1 : '0;
      end
   end

   // ===========================================
   // reference tracking: creep one count per burst when idle
   always_ff @(posedge core_clk) begin
      if (rst) begin
         ref_r <= '0;
         ref_ok_r <= 1'b0;
         res_r <= '0;
      end else begin
         if (adc_done) begin
            res_r <= adc_res;
         end
         if (recal || (eval && !ref_ok_r)) begin
            ref_r <= res_r;
            ref_ok_r <= 1'b1;
         end else if (eval && !detect_r && !hit && filt_r == 3'h0) begin
            // slow drift keeps the ratio valid as the sample cap ages
            if (res_r > ref_r) begin
               ref_r <= ref_r + 1'b1;
            end else if (res_r < ref_r) begin
               ref_r <= ref_r - 1'b1;
            end
         end
      end
   end

   // ===========================================
   // output modes, health pulse and pin polarity
   wire out_state = straps.toggle ? tog_r : detect_r;
   wire pulse_mode = straps.pulse && ACTIVE_LOW;
   wire pulse_act = (pulse_r != '0);
   wire hb_act = (hb_r != '0);
   wire hb_due = eval && (hbn_r == HN_W'(tds_pkg::HB_BURSTS - 1));
   wire pin_act = (pulse_mode ? pulse_act : out_state) ^ hb_act;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         tog_r <= 1'b0;
         pulse_r <= '0;
         hbn_r <= '0;
         hb_r <= '0;
         det_out <= ACTIVE_LOW;
      end else begin
         tog_r <= tog_r ^ det_rise;
         // one pulse per burst while the output state is on
         if (pulse_mode && eval && out_state) begin
            pulse_r <= PU_W'(tds_pkg::PULSE_CYC);
         end else if (pulse_act) begin
            pulse_r <= pulse_r - 1'b1;
         end
         if (eval) begin
            hbn_r <= hb_due ? '0 : hbn_r + 1'b1;
         end
         if (hb_due) begin
            hb_r <= HB_W'(tds_pkg::HB_CYC);
         end else if (hb_act) begin
            hb_r <= hb_r - 1'b1;
         end
         det_out <= pin_act ^ ACTIVE_LOW;
      end
   end

   // ===========================================
   // confirmation tone, differential across the sense terminals
   wire tone_act = (tone_r != '0);
   wire half_wrap = (half_r == TH_W'(tds_pkg::TONE_HALF_CYC - 1));

   always_ff @(posedge core_clk) begin
      if (rst) begin
         tone_r <= '0;
         half_r <= '0;
         phase_r <= 1'b0;
         sense_terminal_a_drv <= 1'b0;
         sense_terminal_b_drv <= 1'b0;
      end else begin
         if (det_rise) begin
            tone_r <= TN_W'(TONE_CYC);
            half_r <= '0;
            phase_r <= 1'b0;
         end else if (tone_act) begin
            tone_r <= tone_r - 1'b1;
            half_r <= half_wrap ? '0 : half_r + 1'b1;
            phase_r <= phase_r ^ half_wrap;
         end
         sense_terminal_a_drv <= tone_act && phase_r;
         sense_terminal_b_drv <= tone_act && !phase_r;
      end
   end

   // ===========================================
   // wishbone decode: ack one cycle after request, one cycle long
   wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   wire wr = req && wb_we_i && wb_sel_i[0];
   wire rd = req && !wb_we_i;
   wire sel_ctrl = (wb_adr_i == tds_pkg::REG_CTRL);
   wire sel_stat = (wb_adr_i == tds_pkg::REG_STAT);
   wire sel_res = (wb_adr_i == tds_pkg::REG_RESULT);
   wire sel_ref = (wb_adr_i == tds_pkg::REG_REF);
   wire sel_ist = (wb_adr_i == tds_pkg::REG_INT_STAT);
   wire sel_imk = (wb_adr_i == tds_pkg::REG_INT_MASK);
   wire [31:0] stat_word = {26'h0, tone_act, filt_r, out_state, detect_r};
   wire [31:0] rd_mux =
      sel_ctrl ? {30'h0, ctrl_r} :
      sel_stat ? stat_word :
      sel_res ? {18'h0, res_r} :
      sel_ref ? {18'h0, ref_r} :
      sel_ist ? {28'h0, int_stat_r} :
      sel_imk ? {28'h0, int_mask_r} : 32'h0;

   // ===========================================
   // interrupt events: set wins over the read that clears
   wire [tds_pkg::INT_W-1:0] ev = {adc_done, recal && detect_r, det_fall, det_rise};
   wire [tds_pkg::INT_W-1:0] ist_clr = (rd && sel_ist) ? int_stat_r : '0;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0;
         ctrl_r <= tds_pkg::CTRL_RST;
         recal_req_r <= 1'b0;
         int_mask_r <= tds_pkg::INT_MASK_RST;
         int_stat_r <= '0;
         irq <= 1'b0;
      end else begin
         wb_ack_o <= req;
         wb_dat_o <= rd ? rd_mux : 32'h0;
         recal_req_r <= wr && sel_ctrl && wb_dat_i[tds_pkg::CTRL_RECAL_BIT];
         if (wr && sel_ctrl) begin
            ctrl_r <= {1'b0, wb_dat_i[tds_pkg::CTRL_EN_BIT]};
         end
         if (wr && sel_imk) begin
            int_mask_r <= wb_dat_i[tds_pkg::INT_W-1:0];
         end
         int_stat_r <= (int_stat_r & ~ist_clr) | ev;
         irq <= |(((int_stat_r & ~ist_clr) | ev) & int_mask_r);
      end
   end
endmodule
`default_nettype wire

// ---- test/tds_core_assertions.sv ----
/*
 tds_core_assertions: checker bound to tds_touch_core.
 assumes a classic wishbone master and one clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
// ====================
// checker
module tds_core_checker #(
   parameter bit ACTIVE_LOW = 1'b1
) (
   input wire logic core_clk, // clock
   input wire logic rst, // sync reset
   input wire logic wb_cyc_i, // cycle
   input wire logic wb_stb_i, // strobe
   input wire logic wb_we_i, // write
   input wire logic [7:0] wb_adr_i, // address
   input wire logic [31:0] wb_dat_o, // read data
   input wire logic wb_ack_o, // ack
   input wire logic level_reached, // comparator
   input wire logic charge_sw, // charge strobe
   input wire logic xfer_sw, // transfer strobe
   input wire logic det_out, // detect pin
   input wire logic sense_terminal_a_drv, // tone a
   input wire logic sense_terminal_b_drv // tone b
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);
   logic req;
   // a request still waiting for its answer
   assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   a_ack_prompt: assert property (req |=> wb_ack_o)
      else $error("ack not one cycle after request");
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_dat_quiet: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("read data outside ack");
   a_unmapped_zero: assert property (req && !wb_we_i && wb_adr_i == 8'h18 |=> wb_dat_o == 32'h0)
      else $error("unmapped read not zero");
   a_xfer_follows: assert property (charge_sw |=> xfer_sw && !charge_sw)
      else $error("transfer does not follow charge");
   a_burst_continue: assert property (xfer_sw && !level_reached |=> charge_sw)
      else $error("burst stopped early");
   a_burst_stop: assert property (xfer_sw && level_reached |=> !charge_sw [*8])
      else $error("burst ran past level");
   a_tone_split: assert property (!(sense_terminal_a_drv && sense_terminal_b_drv))
      else $error("tone drives not complementary");
   a_tone_swap: assert property ($rose(sense_terminal_a_drv) |-> $fell(sense_terminal_b_drv))
      else $error("tone terminals not swapped together");
   a_det_release: assert property ($fell(rst) |-> det_out == ACTIVE_LOW)
      else $error("detect pin active out of reset");
endmodule
bind tds_touch_core tds_core_checker #(.ACTIVE_LOW(ACTIVE_LOW)) u_chk (
   .core_clk(core_clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .level_reached(level_reached), .charge_sw(charge_sw), .xfer_sw(xfer_sw),
   .det_out(det_out), .sense_terminal_a_drv(sense_terminal_a_drv),
   .sense_terminal_b_drv(sense_terminal_b_drv));
`default_nettype wire

// ---- test/tds_sense_model.sv ----
/*
 tds_sense_model: sample-cap comparator beside the electrode.
 assumes charge_sw leads each xfer_sw by one cycle; target set by the bench.
*/
`timescale 1ns/1ps
`default_nettype none
// ====================
// comparator model
module tds_sense_model (
   input wire logic core_clk, // clock
   input wire logic rst, // sync reset
   input wire logic charge_sw, // charge strobe
   input wire logic xfer_sw, // transfer strobe
   input wire logic [13:0] target, // transfers to reach level
   output logic level_reached // comparator out
);
   logic [13:0] cnt_r;
   // level settles in the charge cycle; flips after xfer so nothing stale lingers
   always_ff @(posedge core_clk) begin
      if (rst) begin
         cnt_r <= 14'h0;
         level_reached <= 1'b0;
      end else begin
         if (xfer_sw) begin
            cnt_r <= level_reached ? 14'h0 : cnt_r + 14'h1;
         end
         if (charge_sw) begin
            level_reached <= (cnt_r + 14'h1 >= target);
         end else if (xfer_sw) begin
            level_reached <= ~level_reached;
         end
      end
   end
endmodule
`default_nettype wire

// ---- test/touch_detect_sequencer_bench.sv ----
/*
 touch_detect_sequencer_bench: self-checking bench for tds_touch_core.
 assumes the comparator model and shortened burst and recal counts.
*/
`timescale 1ns/1ps
`default_nettype none
// ====================
// bench
module touch_detect_sequencer_bench;
   localparam int BP = 640;
   localparam int RS = 1500;
   localparam int RLG = 3000;
   typedef struct packed {
      logic [4:0] s;
      logic [13:0] t;
      logic d;
   } tds_row_type;
   // gain rows: open, high, mid, low against a reference of 32
   tds_row_type rows [6] = '{'{5'h00, 14'd30, 1'b1}, '{5'h18, 14'd30, 1'b1},
      '{5'h08, 14'd30, 1'b0}, '{5'h08, 14'd28, 1'b1}, '{5'h10, 14'd28, 1'b0},
      '{5'h10, 14'd24, 1'b1}};
   logic core_clk, rst, cyc, stb, we, ack, irq, lvl, chg, xfr, det, ta, tb;
   logic [7:0] adr;
   logic [3:0] sel;
   logic [31:0] wd, rd, rdat;
   logic [13:0] target;
   tds_pkg::tds_strap_type straps;
   int n_errors = 0;
   int compares = 0;
   int cycles = 0;
   int n;
   int k;
   tds_touch_core #(.BURST_CYC(BP), .TONE_CYC(5000), .RECAL_SHORT_CYC(RS),
      .RECAL_LONG_CYC(RLG)) dut (.core_clk(core_clk), .rst(rst), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd),
      .wb_dat_o(rd), .wb_ack_o(ack), .irq(irq), .straps(straps), .level_reached(lvl),
      .charge_sw(chg), .xfer_sw(xfr), .det_out(det), .sense_terminal_a_drv(ta),
      .sense_terminal_b_drv(tb));
   tds_sense_model model (.core_clk(core_clk), .rst(rst), .charge_sw(chg), .xfer_sw(xfr),
      .target(target), .level_reached(lvl));
   // clock
   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end
   // hang guard, sized well above the planned run
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 100000) begin
         n_errors++;
         $display("mismatch %0t timeout", $time);
         end_of_test();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   // classic single cycle: hold until ack, take data at that edge
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wd <= d;
      // no local limit: only the hang guard ends a wait for ack
      do begin
         @(posedge core_clk);
      end while (ack !== 1'b1);
      rdat = rd;
      if (w) chk(rd, 32'h0, "write data quiet");
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask
   // one burst with the electrode at transfer count t
   task automatic burst(input logic [13:0] t);
      int j;
      target <= t;
      j = 0;
      do begin
         @(posedge core_clk);
         j++;
      end while (!(xfr === 1'b1 && lvl === 1'b1) && j < 3 * BP);
      if (j == 3 * BP) chk(0, 1, "no burst");
      repeat (4) @(posedge core_clk);
   endtask
   task automatic reset_with(input logic [4:0] s);
      @(posedge core_clk);
      rst <= 1'b1;
      straps <= s;
      target <= 14'd32;
      repeat (8) @(posedge core_clk);
      rst <= 1'b0;
   endtask
   task automatic stat();
      bus(1'b0, tds_pkg::REG_STAT, 32'h0);
   endtask
   task automatic end_of_test();
      $display("compares %0d n_errors %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // main sequence
   initial begin
      rst = 1'b1;
      cyc = 1'b0;
      stb = 1'b0;
      we = 1'b0;
      adr = 8'h0;
      sel = 4'hf;
      wd = 32'h0;
      target = 14'd32;
      straps = 5'h0;
      foreach (rows[i]) begin
         reset_with(rows[i].s);
         repeat (2) burst(14'd32);
         repeat (4) burst(rows[i].t);
         stat();
         chk(rdat[0], rows[i].d, "gain row");
         bus(1'b0, tds_pkg::REG_RESULT, 32'h0);
         chk(rdat[13:0], rows[i].t, "result");
         // forced recal drops detection and takes the last result as reference
         bus(1'b1, tds_pkg::REG_CTRL, 32'h3);
         stat();
         chk(rdat[0], 1'b0, "forced recal");
         bus(1'b0, tds_pkg::REG_REF, 32'h0);
         chk(rdat[13:0], rows[i].t, "ref after recal");
      end
      $display("gain rows done");
      for (int l = 0; l < 2; l++) begin
         reset_with(l ? 5'h1c : 5'h18);
         bus(1'b0, tds_pkg::REG_CTRL, 32'h0);
         chk(rdat, 32'h1, "ctrl reset");
         repeat (2) burst(14'd32);
         repeat (3) burst(14'd24);
         burst(14'd32);
         repeat (3) burst(14'd24);
         stat();
         chk({rdat[4:2], rdat[0]}, 4'h6, "filter restart");
         burst(14'd24);
         stat();
         chk({rdat[5], rdat[0]}, 2'h3, "detect and tone");
         n = 0;
         do begin
            burst(14'd24);
            stat();
            n++;
         end while (rdat[0] && n < 9);
         chk(n, (l ? RLG : RS) / BP + 1, "recal bursts");
      end
      bus(1'b0, tds_pkg::REG_INT_STAT, 32'h0);
      chk(rdat & 32'h5, 32'h5, "int rise and recal");
      bus(1'b0, 8'h18, 32'h0);
      chk(rdat, 32'h0, "unmapped");
      bus(1'b1, tds_pkg::REG_INT_MASK, 32'h8);
      burst(14'd24);
      chk(irq, 1'b1, "irq set");
      bus(1'b0, tds_pkg::REG_INT_STAT, 32'h0);
      chk(rdat & 32'h5, 32'h0, "int cleared");
      repeat (2) @(posedge core_clk);
      chk(irq, 1'b0, "irq clear");
      bus(1'b1, tds_pkg::REG_INT_MASK, 32'h0);
      burst(14'd24);
      chk(irq, 1'b0, "irq masked");
      bus(1'b1, tds_pkg::REG_CTRL, 32'h0);
      k = 0;
      repeat (3 * BP) begin
         @(posedge core_clk);
         k += chg;
      end
      chk(k, 0, "disabled bursts");
      $display("recal and bus done");
      // toggle: second touch turns the output off
      reset_with(5'h1a);
      repeat (2) burst(14'd32);
      repeat (4) burst(14'd24);
      stat();
      chk(rdat[1:0], 2'h3, "toggle on");
      burst(14'd32);
      stat();
      chk(rdat[1:0], 2'h2, "toggle held");
      repeat (4) burst(14'd24);
      stat();
      chk(rdat[1:0], 2'h1, "toggle off");
      // idle pin: one health inversion per sixteen bursts
      reset_with(5'h18);
      repeat (2) burst(14'd32);
      k = 0;
      repeat (16 * BP) begin
         @(posedge core_clk);
         k += (det === 1'b0);
      end
      chk(k, tds_pkg::HB_CYC, "health pulse");
      // pulse mode: detection shows as pulses, never a steady level
      reset_with(5'h19);
      repeat (2) burst(14'd32);
      repeat (4) burst(14'd24);
      // first pulse follows the burst after the rise; count one whole pulse
      burst(14'd24);
      k = 0;
      repeat (BP) begin
         @(posedge core_clk);
         k += (det === 1'b0);
      end
      chk(k > 0 && k < BP, 1'b1, "pulse output");
      // tone still running: exactly one terminal high, both halves seen
      k = 0;
      n = 0;
      repeat (2 * tds_pkg::TONE_HALF_CYC) begin
         @(posedge core_clk);
         k += ta;
         n += tb;
      end
      chk(k > 0 && n > 0 && k + n == 2 * tds_pkg::TONE_HALF_CYC, 1'b1, "tone drive");
      $display("output modes done");
      end_of_test();
   end
endmodule
`default_nettype wire
